// ==== rtl/phy_interrupt_and_ext_control.sv ====
// Second extended control register and interrupt mask/status logic of one PHY port
// ************************************
// Functional notes
// ************************************
// Functional notes
// R1: Edge-rate field bits 15:13; 011 slowest, 100 fastest; resets to 000.
// R2: Bit 12 is a sticky reduced power enable, default off.
// R3: Jumbo field bits 5:4: 00 1.5k, 01 9k, 10 12k, 11 reserved.
// R4: Jumbo lengths assume 100 ppm; tighter clocks allow 12k or 16k.
// R5: Mask bit 15 enables interrupt pin, which then follows status bit 15.
// R6: Clearing pin enable blocks only the pin; capture keeps running.
// R7: Station should read status once before enabling the pin.
// R8: Mask bits 14:0 are sticky enables, bit 7 reserved, all reset zero.
// R9: Status bits 14 to 5 report the listed link and FIFO events.
// R10: Status bits 4 to 0 report media, carrier, downshift, resolution, rx error.
// R11: A status read returns pending bits and clears them.
// R12: Status bit 15 flags a pending interrupt; bits 14:0 give cause.
// R13: Speed and duplex change events need autonegotiation enabled.
// R14: Downshift event needs advertisement bits 8:5 of register 4 set.
// R15: No rx error event while rx error decodes carrier extension.
// R16: Autonegotiation enable is control bit 12 of register 0.
// R17: Sticky bits survive soft reset while sticky-reset enable is set.
// R18: Summary bit sets on any enabled event, clears on status read.
// R19: Bit 0 is connector loopback enable; reserved bits read zero.
`timescale 1ns/10ps
module phy_interrupt_and_ext_control (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic SOFT_RESET,
  input wire logic STICKY_RESET_EN,
  input wire logic [4:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic [14:0] EVENT_IN,
  input wire logic AUTONEG_ENABLE,
  input wire logic [3:0] ADV_SPEED_BITS,
  input wire logic RX_ER_CARRIER_EXT,
  output logic [2:0] EDGE_RATE,
  output logic REDUCED_POWER,
  output logic [1:0] JUMBO_MODE,
  output logic CONN_LOOPBACK,
  input wire logic MGMT_IRQ_PIN_I,
  output logic MGMT_IRQ_PIN_O,
  output logic MGMT_IRQ_PIN_OE_N
);
  // ************************************
  // Decode
  // ************************************
  logic [15:0] mask;
  logic [14:0] status_bits;
  logic summary;
  logic [15:0] status_word;
  logic [15:0] ctrl_word;
  wire sel_ctrl = (REG_ADDR == phy_irq_pkg::ADDR_EXT_PHY_CONTROL_TWO);
  wire sel_mask = (REG_ADDR == phy_irq_pkg::ADDR_INTERRUPT_ENABLE_MASK);
  wire sel_status = (REG_ADDR == phy_irq_pkg::ADDR_INTERRUPT_PENDING_STATUS);
  wire wr_ctrl = REG_WR & sel_ctrl;
  wire wr_mask = REG_WR & sel_mask;
  wire rd_status = REG_RD & sel_status; // R11
  // Sticky state returns to defaults only when retention is off
  wire sticky_clear = SOFT_RESET & ~STICKY_RESET_EN; // R17

  // ************************************
  // Event qualification
  // ************************************
  logic [14:0] qualified;
  always_comb begin
    qualified = EVENT_IN;
    qualified[phy_irq_pkg::EV_SPEED] = EVENT_IN[phy_irq_pkg::EV_SPEED] & AUTONEG_ENABLE; // R13
    qualified[phy_irq_pkg::EV_DUPLEX] = EVENT_IN[phy_irq_pkg::EV_DUPLEX] & AUTONEG_ENABLE; // R13
    qualified[phy_irq_pkg::EV_DOWNSHIFT] = EVENT_IN[phy_irq_pkg::EV_DOWNSHIFT]
                                         & (&ADV_SPEED_BITS); // R14
    qualified[phy_irq_pkg::EV_RX_ERROR] = EVENT_IN[phy_irq_pkg::EV_RX_ERROR]
                                        & ~RX_ER_CARRIER_EXT; // R15
  end

  // ************************************
  // Pending status bits
  // ************************************
  // Capture ignores the pin enable entirely
  genvar g;
  generate
    for (g = 0; g < phy_irq_pkg::NUM_EVENTS; g = g + 1) begin : g_ev
      event_capture_bit u_bit (
        .clk(MCLK),
        .rst_b(RST_B),
        .set(qualified[g]), // R9 R10 R6
        .read_clear(rd_status), // R11
        .soft_clear(SOFT_RESET),
        .pending(status_bits[g])
      );
    end
  endgenerate

  wire enabled_event = |(qualified & mask[14:0]);
  event_capture_bit u_summary (
    .clk(MCLK),
    .rst_b(RST_B),
    .set(enabled_event), // R18 R12
    .read_clear(rd_status),
    .soft_clear(SOFT_RESET),
    .pending(summary)
  );
  assign status_word = {summary, status_bits};

  // ************************************
  // Control and mask registers
  // ************************************
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      EDGE_RATE <= phy_irq_pkg::EDGE_RATE_RESET; // R1
      REDUCED_POWER <= 1'b0; // R2
      JUMBO_MODE <= phy_irq_pkg::JUMBO_RESET; // R3
      CONN_LOOPBACK <= 1'b0; // R19
    end else if (sticky_clear) begin
      EDGE_RATE <= phy_irq_pkg::EDGE_RATE_RESET; // R17
      REDUCED_POWER <= 1'b0;
      JUMBO_MODE <= phy_irq_pkg::JUMBO_RESET;
      CONN_LOOPBACK <= 1'b0;
    end else if (wr_ctrl) begin
      EDGE_RATE <= REG_WDATA[phy_irq_pkg::EDGE_RATE_MSB:phy_irq_pkg::EDGE_RATE_LSB]; // R1
      REDUCED_POWER <= REG_WDATA[phy_irq_pkg::REDUCED_POWER_BIT]; // R2
      // Reserved code is stored as written; its length is undefined (R4 assumes 100 ppm)
      JUMBO_MODE <= REG_WDATA[phy_irq_pkg::JUMBO_MSB:phy_irq_pkg::JUMBO_LSB]; // R3 R4
      CONN_LOOPBACK <= REG_WDATA[phy_irq_pkg::CONN_LOOPBACK_BIT]; // R19
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      mask <= phy_irq_pkg::MASK_RESET;
    end else if (sticky_clear) begin
      mask <= phy_irq_pkg::MASK_RESET; // R17
    end else if (wr_mask) begin
      mask <= REG_WDATA & phy_irq_pkg::MASK_WRITABLE; // R8
    end
  end

  always_comb begin
    ctrl_word = 16'h0000; // R19
    ctrl_word[phy_irq_pkg::EDGE_RATE_MSB:phy_irq_pkg::EDGE_RATE_LSB] = EDGE_RATE;
    ctrl_word[phy_irq_pkg::REDUCED_POWER_BIT] = REDUCED_POWER;
    ctrl_word[phy_irq_pkg::JUMBO_MSB:phy_irq_pkg::JUMBO_LSB] = JUMBO_MODE;
    ctrl_word[phy_irq_pkg::CONN_LOOPBACK_BIT] = CONN_LOOPBACK;
  end

  // ************************************
  // Read data
  // ************************************
  logic [15:0] next_rdata;
  always_comb begin
    if (sel_ctrl) begin
      next_rdata = ctrl_word;
    end else if (sel_mask) begin
      next_rdata = mask;
    end else if (sel_status) begin
      next_rdata = status_word; // R11
    end else begin
      next_rdata = 16'h0000;
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end
  end

  // ************************************
  // Interrupt pin
  // ************************************
  // Open drain: only ever pulls low, so the output bit stays zero
  wire next_pin_active = mask[phy_irq_pkg::PIN_ENABLE_BIT] & summary; // R5 R6
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      MGMT_IRQ_PIN_OE_N <= 1'b1;
      MGMT_IRQ_PIN_O <= 1'b0;
    end else begin
      MGMT_IRQ_PIN_OE_N <= ~next_pin_active; // R5
      MGMT_IRQ_PIN_O <= 1'b0;
    end
  end

  // ************************************
  // Assertions
  // ************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  sequence s_status_read;
    rd_status && !SOFT_RESET;
  endsequence
  sequence s_no_new_event;
    !enabled_event && (qualified == 15'h0000);
  endsequence

  a_pin_follows_summary: assert property ( // R5
    ##1 (MGMT_IRQ_PIN_OE_N == !($past(mask[15]) && $past(summary))))
    else $error("Interrupt pin does not follow pending summary");
  a_pin_blocked: assert property (!mask[15] |=> MGMT_IRQ_PIN_OE_N) // R6
    else $error("Interrupt pin asserted while disabled");
  a_capture_unmasked: assert property ( // R6
    qualified[3] && !mask[3] |=> status_bits[3])
    else $error("Event lost while its enable was clear");
  a_read_clears: assert property ( // R11
    s_status_read ##0 s_no_new_event |=> (status_word == 16'h0000))
    else $error("Status read did not clear pending bits");
  a_read_returns: assert property ( // R11
    s_status_read |=> (REG_RDATA == $past(status_word)))
    else $error("Status read returned wrong value");
  a_summary_set: assert property (enabled_event |=> summary) // R18
    else $error("Enabled event did not raise summary");
  a_speed_gated: assert property ( // R13
    EVENT_IN[14] && !AUTONEG_ENABLE && !status_bits[14] |=> !status_bits[14])
    else $error("Speed event raised without autonegotiation");
  a_downshift_gated: assert property ( // R14
    EVENT_IN[2] && (ADV_SPEED_BITS != 4'hf) && !status_bits[2] |=> !status_bits[2])
    else $error("Downshift event raised without advertisement");
  a_rxer_gated: assert property ( // R15
    EVENT_IN[0] && RX_ER_CARRIER_EXT && !status_bits[0] |=> !status_bits[0])
    else $error("Receive error event during carrier extension");
  a_mask_reserved: assert property (mask[7] == 1'b0) // R8
    else $error("Reserved mask bit set");
  a_sticky_keep: assert property ( // R17
    SOFT_RESET && STICKY_RESET_EN && !REG_WR |=> $stable(mask) && $stable(EDGE_RATE))
    else $error("Sticky bits lost across soft reset");
  a_ctrl_write: assert property ( // R1
    wr_ctrl && !sticky_clear |=> (EDGE_RATE == $past(REG_WDATA[15:13]))
      && (JUMBO_MODE == $past(REG_WDATA[5:4])) && (REDUCED_POWER == $past(REG_WDATA[12])))
    else $error("Control register write not stored");
  a_ctrl_reserved: assert property ( // R19
    REG_RD && sel_ctrl |=> (REG_RDATA[11:6] == 6'h00) && (REG_RDATA[3:1] == 3'h0))
    else $error("Reserved control bits read nonzero");
endmodule : phy_interrupt_and_ext_control

// ==== rtl/phy_irq_pkg.sv ====
// Register map, field layout and reset values of the interrupt and control block
package phy_irq_pkg;
  // ************************************
  // Register addresses
  // ************************************
  localparam logic [4:0] ADDR_EXT_PHY_CONTROL_TWO = 5'h18;
  localparam logic [4:0] ADDR_INTERRUPT_ENABLE_MASK = 5'h19;
  localparam logic [4:0] ADDR_INTERRUPT_PENDING_STATUS = 5'h1a;
  // ************************************
  // Control register fields
  // ************************************
  localparam int EDGE_RATE_MSB = 15;
  localparam int EDGE_RATE_LSB = 13;
  localparam int REDUCED_POWER_BIT = 12;
  localparam int JUMBO_MSB = 5;
  localparam int JUMBO_LSB = 4;
  localparam int CONN_LOOPBACK_BIT = 0;
  localparam logic [2:0] EDGE_RATE_RESET = 3'h0;
  localparam logic [2:0] EDGE_RATE_SLOWEST = 3'h3;
  localparam logic [2:0] EDGE_RATE_FASTEST = 3'h4;
  localparam logic [1:0] JUMBO_RESET = 2'h0;
  // Jumbo codes: 1.5 kB, 9 kB (12 kB at 60 ppm), 12 kB (16 kB at 70 ppm), reserved
  localparam logic [1:0] JUMBO_STANDARD = 2'h0;
  localparam logic [1:0] JUMBO_9K = 2'h1;
  localparam logic [1:0] JUMBO_12K = 2'h2;
  localparam logic [1:0] JUMBO_RESERVED = 2'h3;
  // ************************************
  // Interrupt fields
  // ************************************
  localparam int NUM_EVENTS = 15;
  localparam int PIN_ENABLE_BIT = 15;
  localparam int SUMMARY_BIT = 15;
  localparam int EV_SPEED = 14;
  localparam int EV_LINK = 13;
  localparam int EV_DUPLEX = 12;
  localparam int EV_RESERVED = 7;
  localparam int EV_DOWNSHIFT = 2;
  localparam int EV_RX_ERROR = 0;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] MASK_WRITABLE = 16'hff7f;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
endpackage : phy_irq_pkg

// ==== rtl/event_capture_bit.sv ====
// One pending event bit: set by an event, cleared by a status read or soft reset
`timescale 1ns/10ps
module event_capture_bit (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic set,
  input wire logic read_clear,
  input wire logic soft_clear,
  output logic pending
);
  // Set wins over a read in the same cycle so no event is lost
  logic next_pending;
  assign next_pending = set | (pending & ~read_clear & ~soft_clear);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending <= 1'b0;
    end else begin
      pending <= next_pending;
    end
  end
endmodule : event_capture_bit

// ==== bench/mgmt_station.sv ====
// Management station model driving the strobe register port
`timescale 1ns/10ps
module mgmt_station (
  input wire logic MCLK,
  output logic [4:0] REG_ADDR,
  output logic [15:0] REG_WDATA,
  output logic REG_WR,
  output logic REG_RD
);
  initial begin
    REG_ADDR = 5'h00;
    REG_WDATA = 16'h0000;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  end
  // ************************************
  // Bus cycles
  // ************************************
  // Released address and data lines show inverted values, so a stale address never stays on the bus; 5'h05 inverts to the status address 5'h1a
  task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] data);
    REG_ADDR = addr;
    REG_WDATA = data;
    REG_WR = wr;
    REG_RD = !wr;
    @(posedge MCLK);
    @(negedge MCLK);
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = ~addr;
    REG_WDATA = ~data;
    @(posedge MCLK);
    @(negedge MCLK);
  endtask : access
  task automatic rd_reg(input logic [4:0] addr);
    access(1'b0, addr, 16'h0000);
  endtask : rd_reg
  task automatic wr_reg(input logic [4:0] addr, input logic [15:0] data);
    if (addr == phy_irq_pkg::ADDR_INTERRUPT_ENABLE_MASK && data[15]) begin
      access(1'b0, phy_irq_pkg::ADDR_INTERRUPT_PENDING_STATUS, 16'h0000);
    end
    access(1'b1, addr, data);
  endtask : wr_reg
endmodule : mgmt_station

// ==== bench/phy_interrupt_and_ext_control_tb.sv ====
// Self-checking bench with a reference model of the block
`timescale 1ns/10ps
module phy_interrupt_and_ext_control_tb;
  logic MCLK = 1'b0;
  logic RST_B = 1'b0;
  logic SOFT_RESET = 1'b0;
  logic STICKY_RESET_EN = 1'b0;
  logic [14:0] EVENT_IN = 15'h0000;
  logic AUTONEG_ENABLE = 1'b0;
  logic [3:0] ADV_SPEED_BITS = 4'h0;
  logic RX_ER_CARRIER_EXT = 1'b0;
  logic [4:0] REG_ADDR;
  logic [15:0] REG_WDATA, REG_RDATA;
  logic REG_WR, REG_RD, REDUCED_POWER, CONN_LOOPBACK, pin_o, pin_oe_n;
  logic [2:0] EDGE_RATE;
  logic [1:0] JUMBO_MODE;
  logic [15:0] ctrl, mask, rdx;
  logic [14:0] stat, qual;
  logic summ, pin;
  int n_mismatch = 0;
  int n_checks = 0;
  int i;
  logic [15:0] r;
  wire pin_wire = pin_oe_n ? 1'b1 : pin_o;
  always #4 MCLK = ~MCLK;
  mgmt_station i_station (.MCLK(MCLK), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD));
  phy_interrupt_and_ext_control i_dut (.MCLK(MCLK), .RST_B(RST_B), .SOFT_RESET(SOFT_RESET),
    .STICKY_RESET_EN(STICKY_RESET_EN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EVENT_IN(EVENT_IN),
    .AUTONEG_ENABLE(AUTONEG_ENABLE), .ADV_SPEED_BITS(ADV_SPEED_BITS),
    .RX_ER_CARRIER_EXT(RX_ER_CARRIER_EXT), .EDGE_RATE(EDGE_RATE),
    .REDUCED_POWER(REDUCED_POWER), .JUMBO_MODE(JUMBO_MODE), .CONN_LOOPBACK(CONN_LOOPBACK),
    .MGMT_IRQ_PIN_I(pin_wire), .MGMT_IRQ_PIN_O(pin_o), .MGMT_IRQ_PIN_OE_N(pin_oe_n));
  // ************************************
  // Reference model
  // ************************************
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl = 16'h0000;
      mask = 16'h0000;
      stat = 15'h0000;
      summ = 1'b0;
      pin = 1'b1;
      rdx = 16'h0000;
    end else begin
      pin = !(mask[15] && summ);
      qual = EVENT_IN;
      qual[14] = qual[14] & AUTONEG_ENABLE;
      qual[12] = qual[12] & AUTONEG_ENABLE;
      qual[2] = qual[2] & (ADV_SPEED_BITS == 4'hf);
      qual[0] = qual[0] & !RX_ER_CARRIER_EXT;
      if (REG_RD) begin
        rdx = (REG_ADDR == 5'h18) ? ctrl : (REG_ADDR == 5'h19) ? mask :
          (REG_ADDR == 5'h1a) ? {summ, stat} : 16'h0000;
        if (REG_ADDR == 5'h1a) begin
          stat = 15'h0000;
          summ = 1'b0;
        end
      end
      // Soft reset clears pending bits, but an event in the same cycle still lands
      if (SOFT_RESET) begin
        stat = 15'h0000;
        summ = 1'b0;
      end
      stat = stat | qual;
      if (|(qual & mask[14:0])) summ = 1'b1;
      // A write is lost only when the soft reset really clears sticky state
      if (SOFT_RESET && !STICKY_RESET_EN) begin
        ctrl = 16'h0000;
        mask = 16'h0000;
      end else if (REG_WR && REG_ADDR == 5'h18) begin
        ctrl = REG_WDATA & 16'hf031;
      end else if (REG_WR && REG_ADDR == 5'h19) begin
        mask = REG_WDATA & phy_irq_pkg::MASK_WRITABLE;
      end
    end
  end
  // ************************************
  // Comparison and verdict
  // ************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  always @(negedge MCLK) begin
    if (RST_B) begin
      chk(REG_RDATA, rdx);
      chk(16'(EDGE_RATE), 16'(ctrl[15:13]));
      chk(16'(REDUCED_POWER), 16'(ctrl[12]));
      chk(16'(JUMBO_MODE), 16'(ctrl[5:4]));
      chk(16'(CONN_LOOPBACK), 16'(ctrl[0]));
      chk(16'(pin_oe_n), 16'(pin));
      chk(16'(pin_o), 16'h0000);
    end
  end
  function automatic logic [4:0] addr_pick(input logic [1:0] s);
    return (s == 2'h0) ? 5'h18 : (s == 2'h1) ? 5'h19 : (s == 2'h2) ? 5'h1a : 5'h05;
  endfunction : addr_pick
  // ************************************
  // Stimulus
  // ************************************
  initial begin
    void'($urandom(32'ha03f));
    repeat (4) @(posedge MCLK);
    @(negedge MCLK);
    RST_B = 1'b1;
    for (i = 0; i < 4; i++) i_station.rd_reg(addr_pick(2'(i)));
    // Sparse events keep some status reads empty and some full
    for (i = 0; i < 1500; i++) begin
      r = 16'($urandom);
      EVENT_IN = (r[3:0] == 4'h0 || i % 64 == 63) ? 15'($urandom) : 15'h0000;
      AUTONEG_ENABLE = r[4];
      ADV_SPEED_BITS = r[5] ? 4'hf : 4'($urandom);
      RX_ER_CARRIER_EXT = r[6];
      if (i == 750) begin
        // Hardware reset in mid-run; requests may follow at the first edge after it
        RST_B = 1'b0;
        @(negedge MCLK);
        RST_B = 1'b1;
      end else if (i % 64 == 63) begin
        SOFT_RESET = 1'b1;
        STICKY_RESET_EN = i[6];
        @(negedge MCLK);
        SOFT_RESET = 1'b0;
      end else if (r[9:7] == 3'h0) i_station.wr_reg(addr_pick(r[11:10]), 16'($urandom));
      else if (r[9:7] == 3'h1) i_station.rd_reg(addr_pick(r[11:10]));
      else @(negedge MCLK);
    end
    give_verdict;
  end
endmodule : phy_interrupt_and_ext_control_tb
